// ---- dv/ppi_phy_irq_ctrl_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppi_chk
  import ppi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire ppi_phy_status_s PHY_STATUS,
  input wire ppi_phy_ctrl_s PHY_CTRL,
  input wire logic IRQ
);
  logic [7:0] ps;
  logic dv, dw;
  logic [4:0] di;
  wire av = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
  wire rd = dv && !dw;
  wire wr = dv && dw;
  wire ev = |(PHY_STATUS[7:6] & ~ps[7:6]) || (ps[4] && !PHY_STATUS[4]) || |(PHY_STATUS[5:1] & 5'h17);
  always_ff @(posedge CLOCK) begin
    ps <= PHY_STATUS;
    dv <= av;
    dw <= HWRITE;
    di <= HADDR[6:2];
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  AST_RSTV: assert property ($rose(RSTN) |-> PHY_CTRL[3:2] == 2'h0)
    else $error("ctrl reset");
  AST_CTRL: assert property ($changed(PHY_CTRL[3:2]) |-> $past(wr) || $past(wr, 2))
    else $error("ctrl moved");
  AST_POL: assert property (rd && di == IDX_SPECIAL && $stable(PHY_STATUS[0]) |->
    HRDATA[4] == PHY_STATUS[0]) else $error("polarity");
  AST_RSVS: assert property (rd && di == IDX_SPECIAL |-> (HRDATA & 32'hffff13ef) == 0)
    else $error("special rsvd");
  AST_RSVF: assert property (rd && (di == IDX_IRQ_FLAGS || di == IDX_IRQ_MASK) |->
    (HRDATA & 32'hffffff01) == 0) else $error("irq rsvd");
  AST_RDCLR: assert property (av && !HWRITE && HADDR[6:2] == IDX_IRQ_FLAGS && !ev |=> !IRQ)
    else $error("irq kept");
  AST_EVT: assert property ($rose(IRQ) |-> $past(ev) || $past(wr) || $past(wr, 2))
    else $error("irq cause");
  AST_IDLE: assert property (!dv |-> HRDATA == 32'h0)
    else $error("data idle");
  cover property (rd && di == IDX_IRQ_FLAGS && HRDATA != 32'h0);
  cover property ($fell(IRQ));
  cover property (PHY_CTRL[3:2] == 2'h3);
endmodule
bind ppi_phy_irq_ctrl ppi_chk u_chk (.CLOCK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY,
  .HRDATA, .PHY_STATUS, .PHY_CTRL, .IRQ);
`default_nettype wire

// ---- dv/ppi_phy_irq_ctrl_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppi_phy_irq_ctrl_bench
  import ppi_pkg::*;
();
  // Bit 5 of a marks a write; d is write data or the expected read
  typedef struct packed {logic [5:0] a; logic [15:0] d; logic [3:0] c;} ppi_row_s;
  localparam ppi_row_s ROWS [13] = '{'{6'h1d, 16'h0, 4'h3}, '{6'h1e, 16'h0, 4'h3},
    '{6'h1b, 16'h0, 4'h3}, '{6'h3e, 16'hffff, 4'h3}, '{6'h1e, 16'h00fe, 4'h3},
    '{6'h3b, 16'h9fff, 4'hc}, '{6'h1b, 16'h8c00, 4'hc}, '{6'h3b, 16'ha000, 4'h1},
    '{6'h3b, 16'hc000, 4'h3}, '{6'h3d, 16'hffff, 4'h3}, '{6'h1d, 16'h0, 4'h3},
    '{6'h25, 16'hffff, 4'h3}, '{6'h05, 16'h0, 4'h3}};
  logic CLOCK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
  logic HREADYOUT, HRESP, IRQ;
  ppi_phy_status_s PHY_STATUS = '0;
  ppi_phy_ctrl_s PHY_CTRL;
  int error_cnt = 0, checks_done = 0;
  always #5 CLOCK = ~CLOCK;
  ppi_phy_irq_ctrl u_dut (.CLOCK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY(HREADYOUT), .HREADYOUT, .HRESP, .HRDATA, .PHY_STATUS, .STRAP_XOVER_AUTO(1'b1),
    .STRAP_XOVER_MAN(1'b0), .PHY_CTRL, .IRQ);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [4:0] i, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {25'h0, i, 2'h0};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  // One cycle away from the idle status, where the link is up
  task automatic pulse(input logic [7:0] m);
    PHY_STATUS <= ppi_phy_status_s'(8'h10 ^ m);
    @(posedge CLOCK);
    PHY_STATUS <= ppi_phy_status_s'(8'h10);
    repeat (2) @(posedge CLOCK);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge CLOCK);
    RSTN <= 1'b1;
    foreach (ROWS[k]) begin
      xf(ROWS[k].a[5], ROWS[k].a[4:0], {16'h0, ROWS[k].d});
      if (!ROWS[k].a[5]) chk(q, {16'h0, ROWS[k].d});
      repeat (2) @(posedge CLOCK);
      chk({28'h0, PHY_CTRL}, {28'h0, ROWS[k].c});
      chk({31'h0, HRESP}, 32'h0);
    end
    PHY_STATUS <= ppi_phy_status_s'(8'h10);
    @(posedge CLOCK);
    for (int b = 1; b < 8; b++) begin
      pulse(8'h1 << b);
      chk({31'h0, IRQ}, 32'h1);
      xf(1'b0, IDX_IRQ_FLAGS, 32'h0);
      chk(q, 32'h1 << b);
      chk({31'h0, IRQ}, 32'h0);
    end
    xf(1'b1, IDX_IRQ_MASK, 32'h2);
    pulse(8'h20);
    chk({31'h0, IRQ}, 32'h0);
    xf(1'b0, IDX_IRQ_FLAGS, 32'h0);
    chk(q, 32'h0);
    // Page event held high across the read: the set beats the clear
    PHY_STATUS <= ppi_phy_status_s'(8'h13);
    @(posedge CLOCK);
    xf(1'b0, IDX_IRQ_FLAGS, 32'h0);
    chk(q, 32'h2);
    chk({31'h0, IRQ}, 32'h1);
    PHY_STATUS <= ppi_phy_status_s'(8'h11);
    xf(1'b0, IDX_IRQ_FLAGS, 32'h0);
    chk(q, 32'h2);
    chk({31'h0, IRQ}, 32'h0);
    PHY_STATUS <= ppi_phy_status_s'(8'h11);
    xf(1'b0, IDX_SPECIAL, 32'h0);
    chk(q, 32'hc010);
    xf(1'b1, IDX_SOFT_RESET, 32'h1);
    xf(1'b1, IDX_SOFT_RESET, 32'h2);
    @(posedge CLOCK);
    xf(1'b0, IDX_SPECIAL, 32'h0);
    chk(q, 32'h0010);
    chk({28'h0, PHY_CTRL}, 32'h3);
    // Reset in mid-run with a pending interrupt
    xf(1'b1, IDX_IRQ_MASK, 32'hfe);
    pulse(8'h02);
    chk({31'h0, IRQ}, 32'h1);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk({31'h0, IRQ}, 32'h0);
    RSTN <= 1'b1;
    xf(1'b0, IDX_IRQ_MASK, 32'h0);
    chk(q, 32'h0);
    xf(1'b0, IDX_IRQ_FLAGS, 32'h0);
    chk(q, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire

// ---- verilog/ppi_phy_irq_ctrl.sv ----
// How it works
// - Bit 11 read/write heartbeat test disable, reset zero, one disables test.
// - Bit 10 one forces 10 Mb PLL to reference, receive blocked.
// - Bit 4 read-only shows 10 Mb polarity, one means reversed.
// - Soft-reset-class bits reset by port PHY reset when PHY reset bit set.
// - Crossover bits: 00 straight, 01 crossed, 10 automatic detection.
// - Flags at index 29 read-only, latch on enabled event until cleared.
// - Any read of flag register clears all latched flags except any whose enabled event is present in the same cycle.
// - Flag 7 latches when line energy detected becomes set.
// - Flag 6 latches when auto-negotiation completes.
// - Flag 5 latches on remote fault detection.
// - Flag 4 latches on link down.
// - Flag 3 latches on link partner acknowledge.
// - Flag 2 latches on parallel detection fault.
// - Flag 1 latches on auto-negotiation page received.
// - Mask at index 30, bits 7..1 read/write, reset zero, one enables.
// - Bit 15 selects straps (zero) or register crossover bits (one).
`timescale 1ns/100ps
`default_nettype none
module ppi_phy_irq_ctrl
  import ppi_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire ppi_phy_status_s PHY_STATUS,
  input wire logic STRAP_XOVER_AUTO,
  input wire logic STRAP_XOVER_MAN,
  output ppi_phy_ctrl_s PHY_CTRL,
  output logic IRQ
);

  ppi_state_s s;
  ppi_state_s next_s;
  logic take;
  logic rd_flags;
  logic wr;
  logic soft_rst;
  wire logic [7:1] flags;
  wire logic [7:1] flag_next;
  logic [15:0] wdata;
  logic [15:0] rdval;
  logic eff_auto;
  logic eff_man;

  always_comb begin
    next_s = s;
    take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    wr = s.dph_valid && s.dph_write;
    wdata = HWDATA[15:0];
    // Port PHY reset armed by the PHY reset bit, fired by the global control
    soft_rst = wr && (s.dph_idx == IDX_SOFT_RESET) && wdata[SR_GLOBAL] && s.phy_rst_arm;

    // Zero wait states and always an OKAY response, both held in flops
    next_s.hready = 1'b1;
    next_s.hresp = 1'b0;

    // Read data built in the address phase, returned registered in the data phase
    rdval = '0;
    case (HADDR[ADDR_LSB +: 5])
      IDX_SPECIAL: begin
        rdval[SC_XOVER_SRC] = s.xover_src;
        rdval[SC_XOVER_AUTO] = s.xover_auto;
        rdval[SC_XOVER_MAN] = s.xover_man;
        rdval[SC_HB_OFF] = s.hb_off;
        rdval[SC_PLL_LOCK] = s.pll_lock;
        rdval[SC_POLARITY] = PHY_STATUS.polarity;
      end
      IDX_IRQ_FLAGS: rdval[7:1] = flags;
      IDX_IRQ_MASK: rdval[7:1] = s.mask;
      IDX_SOFT_RESET: rdval[SR_PHY_RST] = s.phy_rst_arm;
      default: rdval = '0;
    endcase
    next_s.hrdata = take && !HWRITE ? {16'h0000, rdval} : 32'h0000_0000;
    next_s.dph_valid = take;
    next_s.dph_write = HWRITE;
    next_s.dph_idx = HADDR[ADDR_LSB +: 5];

    if (wr) begin
      case (s.dph_idx)
        IDX_SPECIAL: begin
          next_s.xover_src = wdata[SC_XOVER_SRC];
          next_s.xover_auto = wdata[SC_XOVER_AUTO];
          next_s.xover_man = wdata[SC_XOVER_MAN];
          next_s.hb_off = wdata[SC_HB_OFF];
          next_s.pll_lock = wdata[SC_PLL_LOCK];
        end
        IDX_IRQ_MASK: next_s.mask = wdata[7:1];
        IDX_SOFT_RESET: next_s.phy_rst_arm = wdata[SR_PHY_RST];
        default: next_s.mask = next_s.mask;
      endcase
    end
    if (soft_rst) begin
      next_s.xover_src = 1'b0;
      next_s.xover_auto = 1'b0;
      next_s.xover_man = 1'b0;
      next_s.hb_off = 1'b0;
      next_s.pll_lock = 1'b0;
      next_s.phy_rst_arm = 1'b0;
    end

    // Crossover mode from straps or register bits
    eff_auto = next_s.xover_src ? next_s.xover_auto : STRAP_XOVER_AUTO;
    eff_man = next_s.xover_src ? next_s.xover_man : STRAP_XOVER_MAN;
    case ({eff_auto, eff_man})
      XOVER_CODE_NONE: next_s.ctrl.crossover_mode = PPI_XOVER_STRAIGHT;
      XOVER_CODE_CROSS: next_s.ctrl.crossover_mode = PPI_XOVER_CROSSED;
      XOVER_CODE_AUTO: next_s.ctrl.crossover_mode = PPI_XOVER_AUTO;
      default: next_s.ctrl.crossover_mode = PPI_XOVER_AUTO;
    endcase
    next_s.ctrl.heartbeat_test_off = next_s.hb_off;
    next_s.ctrl.rx_pll_ref_lock = next_s.pll_lock;
    next_s.irq = |(flag_next & next_s.mask);
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      s <= '0;
      // The slave stays ready through reset so the bus never stalls on it
      s.hready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Kept out of the main process so the flag cells form no loop through it
  assign rd_flags = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && !HWRITE
    && (HADDR[ADDR_LSB +: 5] == IDX_IRQ_FLAGS);

  ppi_flag_cell #(
    .DETECT(PPI_DETECT_RISE)
  ) u_energy_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.energy),
    .enable(s.mask[IRQ_ENERGY]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_ENERGY]),
    .flag(flags[IRQ_ENERGY])
  );

  ppi_flag_cell #(
    .DETECT(PPI_DETECT_RISE)
  ) u_autoneg_done_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.an_done),
    .enable(s.mask[IRQ_ANDONE]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_ANDONE]),
    .flag(flags[IRQ_ANDONE])
  );

  ppi_flag_cell #(
    .DETECT(PPI_DETECT_LEVEL)
  ) u_remote_fault_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.remote_fault),
    .enable(s.mask[IRQ_RFAULT]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_RFAULT]),
    .flag(flags[IRQ_RFAULT])
  );

  // Link down is the falling edge of the link level
  ppi_flag_cell #(
    .DETECT(PPI_DETECT_FALL)
  ) u_link_down_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.link_up),
    .enable(s.mask[IRQ_LINKDN]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_LINKDN]),
    .flag(flags[IRQ_LINKDN])
  );

  ppi_flag_cell #(
    .DETECT(PPI_DETECT_LEVEL)
  ) u_partner_ack_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.partner_ack),
    .enable(s.mask[IRQ_ACK]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_ACK]),
    .flag(flags[IRQ_ACK])
  );

  ppi_flag_cell #(
    .DETECT(PPI_DETECT_LEVEL)
  ) u_parallel_fault_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.parallel_fault),
    .enable(s.mask[IRQ_PFAULT]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_PFAULT]),
    .flag(flags[IRQ_PFAULT])
  );

  ppi_flag_cell #(
    .DETECT(PPI_DETECT_LEVEL)
  ) u_page_rx_flag (
    .clk(CLOCK),
    .rst_n(RSTN),
    .level(PHY_STATUS.page_rx),
    .enable(s.mask[IRQ_PAGE]),
    .clear(rd_flags),
    .next_flag(flag_next[IRQ_PAGE]),
    .flag(flags[IRQ_PAGE])
  );

  assign HREADYOUT = s.hready;
  assign HRESP = s.hresp;
  assign HRDATA = s.hrdata;
  assign PHY_CTRL = s.ctrl;
  assign IRQ = s.irq;

endmodule

// One latched interrupt source: event detection, set, read-clear
module ppi_flag_cell
  import ppi_pkg::*;
#(
  parameter ppi_detect_e DETECT = PPI_DETECT_LEVEL
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic enable,
  input wire logic clear,
  output logic next_flag,
  output logic flag
);

  ppi_cell_s c;
  ppi_cell_s next_c;
  logic hit;

  always_comb begin
    next_c = c;
    next_c.level_d = level;
    case (DETECT)
      PPI_DETECT_RISE: hit = level && !c.level_d;
      PPI_DETECT_FALL: hit = !level && c.level_d;
      PPI_DETECT_LEVEL: hit = level;
      default: hit = level;
    endcase
    if (clear) begin
      next_c.flag = 1'b0;
    end
    // A new event beats a read-clear in the same cycle, so none is lost
    if (hit && enable) begin
      next_c.flag = 1'b1;
    end
    next_flag = next_c.flag;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign flag = c.flag;

endmodule
`default_nettype wire

// ---- verilog/ppi_pkg.sv ----
package ppi_pkg;

  // Register indices (word index; byte address is four times the index)
  localparam logic [4:0] IDX_SPECIAL = 5'h1b;
  localparam logic [4:0] IDX_IRQ_FLAGS = 5'h1d;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h1e;
  localparam logic [4:0] IDX_SOFT_RESET = 5'h1f;
  localparam int ADDR_LSB = 2;

  // Special control/indication fields
  localparam int SC_XOVER_SRC = 15;
  localparam int SC_XOVER_AUTO = 14;
  localparam int SC_XOVER_MAN = 13;
  localparam int SC_HB_OFF = 11;
  localparam int SC_PLL_LOCK = 10;
  localparam int SC_POLARITY = 4;

  // Irq bit positions
  localparam int IRQ_PAGE = 1;
  localparam int IRQ_PFAULT = 2;
  localparam int IRQ_ACK = 3;
  localparam int IRQ_LINKDN = 4;
  localparam int IRQ_RFAULT = 5;
  localparam int IRQ_ANDONE = 6;
  localparam int IRQ_ENERGY = 7;
  localparam logic [15:0] IRQ_VALID = 16'h00fe;

  // Soft reset register bits
  localparam int SR_PHY_RST = 0;
  localparam int SR_GLOBAL = 1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] XOVER_CODE_NONE = 2'h0;
  localparam logic [1:0] XOVER_CODE_CROSS = 2'h1;
  localparam logic [1:0] XOVER_CODE_AUTO = 2'h2;

  typedef enum logic [1:0] {
    PPI_XOVER_STRAIGHT = 2'h0,
    PPI_XOVER_CROSSED = 2'h1,
    PPI_XOVER_AUTO = 2'h3
  } ppi_xover_e;

  // How a flag cell turns its status level into an event
  typedef enum logic [1:0] {
    PPI_DETECT_LEVEL = 2'h0,
    PPI_DETECT_RISE = 2'h1,
    PPI_DETECT_FALL = 2'h3
  } ppi_detect_e;

  typedef struct packed {
    logic level_d;
    logic flag;
  } ppi_cell_s;

  typedef struct packed {
    logic energy;
    logic an_done;
    logic remote_fault;
    logic link_up;
    logic partner_ack;
    logic parallel_fault;
    logic page_rx;
    logic polarity;
  } ppi_phy_status_s;

  typedef struct packed {
    logic heartbeat_test_off;
    logic rx_pll_ref_lock;
    ppi_xover_e crossover_mode;
  } ppi_phy_ctrl_s;

  typedef struct packed {
    logic xover_src;
    logic xover_auto;
    logic xover_man;
    logic hb_off;
    logic pll_lock;
    logic [7:1] mask;
    logic phy_rst_arm;
    logic dph_valid;
    logic dph_write;
    logic [4:0] dph_idx;
    logic [31:0] hrdata;
    logic irq;
    ppi_phy_ctrl_s ctrl;
    logic hready;
    logic hresp;
  } ppi_state_s;

endpackage
